// ==== design/cph_defs.svh ====
`ifndef CPH_DEFS_SVH
`define CPH_DEFS_SVH
// Number of wake request sources
`define CPH_NUM_WAKE      9
// Wake source bit positions
`define CPH_WAKE_DEC      0
`define CPH_WAKE_FIT      1
`define CPH_WAKE_WDOG     2
`define CPH_WAKE_MCHK     3
`define CPH_WAKE_PMON     4
`define CPH_WAKE_DBELL    5
`define CPH_WAKE_DBELL_CR 6
`define CPH_WAKE_GDBELL   7
`define CPH_WAKE_GDBELL_MC 8
// Timebase width and reset value
`define CPH_TB_WIDTH      64
`define CPH_TB_RESET      64'h0000000000000000
`endif

// ==== design/cph_pkg.sv ====
package cph_pkg;
  `include "cph_defs.svh"
  // Activity state, one-hot
  typedef enum logic [4:0] {
    CPH_FULL_ON       = 5'b00001,
    CPH_DRAINING      = 5'b00010,
    CPH_ACTIVITY_HALTED_STATE = 5'b00100,
    CPH_BUS_IDLE_WAIT = 5'b01000,
    CPH_ACTIVITY_CLOCKS_GATED_STATE = 5'b10000
  } cph_state_t;
  typedef logic [`CPH_NUM_WAKE-1:0] cph_wake_t;
endpackage : cph_pkg

// ==== design/cph_sync_if.sv ====
`timescale 1ns/100ps
// Synchronised platform requests handed to the sequencer
interface cph_sync_if;
  logic halt_req;
  logic stop_req;
  logic tb_enable;
  modport src (output halt_req, output stop_req, output tb_enable);
  modport dst (input halt_req, input stop_req, input tb_enable);
endinterface : cph_sync_if

// ==== design/cph_sync.sv ====
`timescale 1ns/100ps
// Two-flop synchronisers for the platform request pins
module cph_sync
  import cph_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Raw pins
  input  wire logic halt_i,
  input  wire logic stop_i,
  input  wire logic tben_i,
  // Synchronised outputs
  cph_sync_if.src   sync
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] raw;
  assign raw = {tben_i, stop_i, halt_i};
  // First stage is only read by second stage
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ff
      always_ff @(posedge clk_i or negedge reset_n_i)
      begin
        if (!reset_n_i)
        begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= raw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate
  assign sync.halt_req  = sync_q[0];
  assign sync.stop_req  = sync_q[1];
  assign sync.tb_enable = sync_q[2];
endmodule : cph_sync

// ==== design/cph_core_power.sv ====
`timescale 1ns/100ps
// Summary of operation
// R1: The platform raises halt to move the core from full operation to the halted state, and the core starts halting.
// R2: The halted output rises only once the core has truly reached the halted activity state.
// R3: Stop raised while halted moves the core to the clock-gated state, and dropping stop returns it to halted.
// R4: The stopped output is high for exactly as long as functional clocks are gated.
// R5: The timebase advances only while the timebase enable input is high.
// R6: Wake request is high whenever an enabled internal asynchronous interrupt is pending.
// R7: Wake sources are decrementer, fixed interval, watchdog, machine check, perf monitor and four doorbell kinds.
// R8: The platform takes a transition as done only after seeing the matching acknowledgement.
// R9: While halted or clock-gated the core ignores external interrupt requests.
// R10: The platform watches external interrupts and the wake request while the core sleeps.
// R11: On an interrupt request the platform drops stop and halt to bring the core back.
// R12: The platform alone keeps power state status; the core has no such register.
// R13: On halting the core stops fetching, drains outstanding work, and keeps clocks and snooping alive.
// R14: On stop the core waits for the system bus to go idle, then gates clocks and asserts stopped on the same edge.
// R15: The timebase enable governs counting in every state, independent of the handshake.
// R16: On wake the core restores clocks and drops stopped first, then drops halted and resumes fetch.
`include "cph_defs.svh"
module cph_core_power
  import cph_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  // Platform power requests (pins)
  input  wire logic                    halt_i,
  input  wire logic                    stop_i,
  input  wire logic                    tben_i,
  // Platform external interrupt
  input  wire logic                    ext_irq_i,
  // Core internal status, same clock
  input  wire logic                    pipe_drained_i,
  input  wire logic                    bus_idle_i,
  input  wire cph_pkg::cph_wake_t      irq_pending_i,
  input  wire cph_pkg::cph_wake_t      irq_enable_i,
  // Acknowledgements to platform
  output logic                         halted_o,
  output logic                         stopped_o,
  output logic                         wake_req_o,
  // Core-side controls
  output logic                         fetch_en_o,
  output logic                         clk_gate_en_o,
  output logic                         ext_irq_take_o,
  output logic [`CPH_TB_WIDTH-1:0]     timebase_o
);

  // ----------------------------------------
  // Request synchronisation
  // ----------------------------------------
  // Pins are async to the core clock; two flops cost two cycles of reaction time
  cph_sync_if sync ();

  cph_sync u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .halt_i    (halt_i),
    .stop_i    (stop_i),
    .tben_i    (tben_i),
    .sync      (sync)
  );

  // ----------------------------------------
  // Activity state machine
  // ----------------------------------------
  cph_state_t state_q;
  cph_state_t state_d;

  // Next state; halt has to be held for the whole halted stay
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      CPH_FULL_ON:
        if (sync.halt_req)
          state_d = CPH_DRAINING;                              // R1
      CPH_DRAINING:
        if (!sync.halt_req)
          state_d = CPH_FULL_ON;
        else if (pipe_drained_i)
          state_d = CPH_ACTIVITY_HALTED_STATE;                 // R13
      CPH_ACTIVITY_HALTED_STATE:
        if (sync.stop_req)
          state_d = CPH_BUS_IDLE_WAIT;                         // R3
        else if (!sync.halt_req)
          state_d = CPH_FULL_ON;                               // R16
      CPH_BUS_IDLE_WAIT:
        if (!sync.stop_req)
          state_d = CPH_ACTIVITY_HALTED_STATE;
        else if (bus_idle_i)
          state_d = CPH_ACTIVITY_CLOCKS_GATED_STATE;           // R14
      CPH_ACTIVITY_CLOCKS_GATED_STATE:
        if (!sync.stop_req)
          state_d = CPH_ACTIVITY_HALTED_STATE;                 // R3
      default:
        state_d = CPH_FULL_ON;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state_q <= CPH_FULL_ON;
    else
      state_q <= state_d;
  end

  // ----------------------------------------
  // Output decode from next state
  // ----------------------------------------
  // Decoded from state_d so every output is a flop yet in step with state
  wire in_halted_d  = (state_d == CPH_ACTIVITY_HALTED_STATE) ||
                      (state_d == CPH_BUS_IDLE_WAIT) ||
                      (state_d == CPH_ACTIVITY_CLOCKS_GATED_STATE);
  wire in_gated_d   = (state_d == CPH_ACTIVITY_CLOCKS_GATED_STATE);
  wire fetch_d      = (state_d == CPH_FULL_ON);
  wire wake_d       = |(irq_pending_i & irq_enable_i);          // R6 R7
  wire irq_take_d   = ext_irq_i && fetch_d;                     // R9

  // Acknowledge and control flops
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      halted_o       <= 1'b0;
      stopped_o      <= 1'b0;
      wake_req_o     <= 1'b0;
      fetch_en_o     <= 1'b1;
      clk_gate_en_o  <= 1'b0;
      ext_irq_take_o <= 1'b0;
    end
    else
    begin
      halted_o       <= in_halted_d;                           // R2
      stopped_o      <= in_gated_d;                            // R4
      clk_gate_en_o  <= in_gated_d;                            // R14
      fetch_en_o     <= fetch_d;                               // R13
      wake_req_o     <= wake_d;                                // R6
      ext_irq_take_o <= irq_take_d;                            // R9
    end
  end

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  // Gated only by the enable, not by the activity state
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      timebase_o <= `CPH_TB_RESET;
    else if (sync.tb_enable)
      timebase_o <= timebase_o + `CPH_TB_WIDTH'(1);            // R5 R15
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  halted_needs_state_a: assert property (                      // R2
    halted_o |-> (state_q != CPH_FULL_ON && state_q != CPH_DRAINING))
    else $error("halted raised before halted state");

  halt_starts_drain_a: assert property (                       // R1
    (state_q == CPH_FULL_ON && sync.halt_req) |=> (state_q == CPH_DRAINING && !fetch_en_o))
    else $error("halt did not start draining");

  stopped_tracks_gate_a: assert property (                     // R4
    stopped_o == clk_gate_en_o)
    else $error("stopped differs from clock gate");

  stop_needs_idle_a: assert property (                         // R14
    $rose(stopped_o) |-> $past(bus_idle_i) && $past(state_q == CPH_BUS_IDLE_WAIT))
    else $error("stopped without bus idle");

  unstop_to_halted_a: assert property (                        // R3
    (stopped_o && !sync.stop_req) |=> (!stopped_o && halted_o))
    else $error("stop removal did not return to halted");

  tb_hold_a: assert property (                                 // R5
    !sync.tb_enable |=> $stable(timebase_o))
    else $error("timebase moved while disabled");

  tb_count_a: assert property (                                // R15
    sync.tb_enable |=> (timebase_o == $past(timebase_o) + `CPH_TB_WIDTH'(1)))
    else $error("timebase did not advance");

  wake_follows_a: assert property (                            // R6
    (|(irq_pending_i & irq_enable_i)) |=> wake_req_o)
    else $error("wake request missing");

  irq_ignored_a: assert property (                             // R9
    halted_o |-> !ext_irq_take_o)
    else $error("external interrupt taken while halted");

  wake_order_a: assert property (                              // R16
    $fell(halted_o) |-> !stopped_o && $past(!stopped_o))
    else $error("halted dropped before stopped");

  // Refusals and unwinding paths
  wake_clears_a: assert property (                             // R6
    !(|(irq_pending_i & irq_enable_i)) |=> !wake_req_o)
    else $error("wake request without enabled pending source");

  drain_abort_a: assert property (                             // R1
    (state_q == CPH_DRAINING && !sync.halt_req) |=> (state_q == CPH_FULL_ON && !halted_o && fetch_en_o))
    else $error("halt removal while draining did not return to full on");

  resume_fetch_a: assert property (                            // R16
    (state_q == CPH_ACTIVITY_HALTED_STATE && !sync.stop_req && !sync.halt_req) |=> (fetch_en_o && !halted_o))
    else $error("fetch not resumed after halt removal");

  stop_after_halt_a: assert property (                         // R3
    stopped_o |-> halted_o)
    else $error("stopped raised outside the halted state");

  halt_stops_fetch_a: assert property (                        // R13
    halted_o |-> !fetch_en_o)
    else $error("fetch enabled while halted");

  full_stop_c: cover property (stopped_o ##1 !stopped_o ##[1:20] !halted_o);
  halt_only_c: cover property ($rose(halted_o) ##[1:20] $fell(halted_o));
  wake_c:      cover property (stopped_o && wake_req_o);
  tb_pause_c:  cover property (sync.tb_enable ##1 !sync.tb_enable);
  drain_abort_c: cover property (state_q == CPH_DRAINING && !sync.halt_req);

endmodule : cph_core_power

// ==== verification/cph_plat_model.sv ====
`timescale 1ns/100ps
// Platform power controller stand-in
module cph_plat_model
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // Bench command and core status
  input  wire logic sleep_i,
  input  wire logic halted_i,
  input  wire logic stopped_i,
  input  wire logic wake_req_i,
  input  wire logic ext_irq_i,
  // Requests to core
  output logic      halt_o,
  output logic      stop_o
);
  logic wake;
  logic waking_q;
  // Platform watches the external interrupt and the core's wake request
  assign wake = wake_req_i | ext_irq_i;
  // All power state lives here; latch a wake until halt is gone
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      halt_o   <= 1'b0;
      stop_o   <= 1'b0;
      waking_q <= 1'b0;
    end
    else if (wake | waking_q)
    begin
      waking_q <= halt_o;
      stop_o   <= 1'b0;
      halt_o   <= halt_o & stopped_i;
    end
    else
    begin
      halt_o <= sleep_i | halt_o;
      stop_o <= sleep_i & halted_i;
    end
  end
endmodule : cph_plat_model

// ==== verification/tb_cph_core_power.sv ====
`timescale 1ns/100ps
`include "cph_defs.svh"
// Self-checking bench for the core power handshake
module tb_cph_core_power;
  import cph_pkg::*;
  logic                     clk_i, reset_n_i, halt, stop, tben, ext_irq, drained, bus_idle, sleep;
  logic                     halted, stopped, wake, fetch, gate, take;
  cph_wake_t                pend, ena;
  logic [`CPH_TB_WIDTH-1:0] tbv, t0;
  int                       fails, cmp_count, cyc, n;

  cph_core_power cph_core_power_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .halt_i(halt), .stop_i(stop),
    .tben_i(tben), .ext_irq_i(ext_irq), .pipe_drained_i(drained), .bus_idle_i(bus_idle),
    .irq_pending_i(pend), .irq_enable_i(ena), .halted_o(halted), .stopped_o(stopped), .wake_req_o(wake),
    .fetch_en_o(fetch), .clk_gate_en_o(gate), .ext_irq_take_o(take), .timebase_o(tbv));
  cph_plat_model cph_plat_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .sleep_i(sleep),
    .halted_i(halted), .stopped_i(stopped), .wake_req_i(wake), .ext_irq_i(ext_irq),
    .halt_o(halt), .stop_o(stop));

  // --------------------------------
  // Clock and hang guard
  // --------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Whole run is a little over a hundred cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      wrap_up();
    end
  end

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wrap_up();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_full_on_irq();
    ext_irq = 1'b1;
    tick(1);
    chk("take", 1, take);
    ext_irq = 1'b0;
    tick(1);
    chk("take_off", 0, take);
  endtask : t_full_on_irq
  // Halt waits for drain, stop waits for bus idle, wake unwinds in order
  task automatic t_sleep_wake();
    sleep = 1'b1;
    tick(8);
    chk("fetch", 0, fetch);
    chk("halted_early", 0, halted);
    drained = 1'b1;
    for (n = 0; n < 20 && halted !== 1'b1; n++) tick(1);
    chk("halted", 1, halted);
    tick(8);
    chk("stopped_early", 0, stopped);
    bus_idle = 1'b1;
    for (n = 0; n < 20 && stopped !== 1'b1; n++) tick(1);
    chk("stopped", 1, stopped);
    chk("gate", 1, gate);
    // Timebase while clocks gated, past the pin synchroniser
    tben = 1'b0;
    tick(4);
    t0 = tbv;
    tick(5);
    chk("tb_hold", t0, tbv);
    tben = 1'b1;
    tick(4);
    t0 = tbv;
    tick(5);
    chk("tb_run", t0 + 64'h5, tbv);
    sleep = 1'b0;
    ext_irq = 1'b1;
    tick(2);
    chk("take_asleep", 0, take);
    for (n = 0; n < 20 && stopped !== 1'b0; n++) tick(1);
    chk("halted_after_stop", 1, halted);
    chk("gate_off", 0, gate);
    for (n = 0; n < 20 && halted !== 1'b0; n++) tick(1);
    chk("fetch_back", 1, fetch);
    chk("take_awake", 1, take);
    ext_irq = 1'b0;
    drained = 1'b0;
    bus_idle = 1'b0;
    tick(4);
  endtask : t_sleep_wake
  // Wake while draining, then while waiting on bus idle: both unwind unfinished
  task automatic t_abort();
    sleep = 1'b1;
    tick(6);
    chk("abort_fetch", 0, fetch);
    sleep = 1'b0;
    ext_irq = 1'b1;
    tick(6);
    chk("abort_halted", 0, halted);
    chk("abort_fetch_back", 1, fetch);
    chk("abort_take", 1, take);
    ext_irq = 1'b0;
    sleep = 1'b1;
    drained = 1'b1;
    for (n = 0; n < 20 && halted !== 1'b1; n++) tick(1);
    chk("abort_halted_2", 1, halted);
    tick(6);
    chk("abort_stop_wait", 0, stopped);
    sleep = 1'b0;
    ext_irq = 1'b1;
    for (n = 0; n < 20 && halted !== 1'b0; n++) tick(1);
    chk("abort_stopped", 0, stopped);
    chk("abort_resume", 1, fetch);
    ext_irq = 1'b0;
    drained = 1'b0;
    tick(4);
  endtask : t_abort
  // Each source alone, then masked
  task automatic t_wake_sources();
    for (int i = 0; i < `CPH_NUM_WAKE; i++)
    begin
      pend = cph_wake_t'(1) << i;
      ena = '1;
      tick(1);
      chk("wake_src", 1, wake);
      ena = ~pend;
      tick(1);
      chk("wake_masked", 0, wake);
    end
    pend = '0;
    tick(4);
  endtask : t_wake_sources

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial
  begin
    {reset_n_i, tben, ext_irq, drained, bus_idle, sleep} = '0;
    pend = '0;
    ena = '0;
    tick(5);
    chk("rst_halted", 0, halted);
    chk("rst_stopped", 0, stopped);
    chk("rst_fetch", 1, fetch);
    chk("rst_tb", 0, tbv);
    tick(1);
    reset_n_i = 1'b1;
    tben = 1'b1;
    tick(3);
    t_full_on_irq();
    t_sleep_wake();
    t_abort();
    t_wake_sources();
    wrap_up();
  end
endmodule : tb_cph_core_power
